// ===== src/tws_pkg.sv
// constants for the two-wire slave transmitter unit
package tws_pkg;
  // register offsets on the plain port
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_STATUS  = 2'h1;
  localparam logic [1:0] ADDR_DATA    = 2'h2;
  localparam logic [1:0] ADDR_OWN     = 2'h3;
  // control register bit positions
  localparam int BIT_ACK   = 2;
  localparam int BIT_INT   = 3;
  localparam int BIT_STOP  = 4;
  localparam int BIT_START = 5;
  localparam int BIT_ARBL  = 6;
  // status codes
  localparam logic [7:0] ST_ADDR_READ = 8'ha8;
  localparam logic [7:0] ST_ARB_READ  = 8'hb0;
  localparam logic [7:0] ST_DATA_ACK  = 8'hb8;
  localparam logic [7:0] ST_DATA_NACK = 8'hc0;
  localparam logic [7:0] ST_LAST_ACK  = 8'hc8;
  localparam logic [7:0] ST_IDLE      = 8'hf8;
  localparam logic [7:0] ST_BUS_ERROR = 8'h00;
  localparam logic [7:0] GC_ADDR      = 8'h00;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] OWN_RESET     = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'hff;
  typedef enum logic [2:0] {
    TWS_IDLE, TWS_ADDR, TWS_ACK_OUT, TWS_WAIT_SW, TWS_TX, TWS_ACK_IN,
    TWS_SKIP
  } tws_state_t;
endpackage : tws_pkg

// ===== src/tws_slave_tx.sv
// two-wire slave transmitter with status codes and bus error handling
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module tws_slave_tx (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            start_pending
);
  // pin synchronisers: first stage feeds only the second
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  // edge and condition detection on synchronised lines
  wire scl_s     = scl_sync[1];
  wire sda_s     = sda_sync[1];
  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  tws_pkg::tws_state_t state;
  tws_pkg::tws_state_t next_state;
  logic [7:0] serial_control_reg;
  logic [7:0] status_code_reg;
  logic [7:0] shift_data_reg;
  logic [7:0] own_address_reg;
  logic [7:0] shifter;
  logic [3:0] bit_cnt;
  logic       last_byte;
  logic       bus_busy;
  logic       drive_sda_low;

  wire ack_enable_flag     = serial_control_reg[tws_pkg::BIT_ACK];
  wire int_flag            = serial_control_reg[tws_pkg::BIT_INT];
  wire stop_request_flag   = serial_control_reg[tws_pkg::BIT_STOP];
  wire start_request_flag  = serial_control_reg[tws_pkg::BIT_START];
  wire arb_lost_flag       = serial_control_reg[tws_pkg::BIT_ARBL];
  wire general_call_enable = own_address_reg[0];

  // software writes to the control, data and own address registers
  wire ctl_wr  = reg_write & (reg_addr == tws_pkg::ADDR_CONTROL);
  wire data_wr = reg_write & (reg_addr == tws_pkg::ADDR_DATA);
  wire own_wr  = reg_write & (reg_addr == tws_pkg::ADDR_OWN);
  // clearing the interrupt flag releases the held state
  wire int_clear = ctl_wr & int_flag & ~reg_wdata[tws_pkg::BIT_INT];
  wire recover   = int_clear & reg_wdata[tws_pkg::BIT_STOP];

  // address match: own address only when acknowledge enabled, general call also needs its own enable
  wire [6:0] addr_rx = shifter[7:1];
  wire own_hit = (addr_rx == own_address_reg[7:1]) & ack_enable_flag;
  wire gc_hit  = (shifter == tws_pkg::GC_ADDR) & general_call_enable
               & ack_enable_flag;
  // read direction only enters slave transmit; writes are not this block
  wire rd_hit  = own_hit & shifter[0];
  // involved in a transfer (unused); in a data byte or acknowledge frame an illegal start or stop is a bus error
  wire involved = (state != tws_pkg::TWS_IDLE) & (state != tws_pkg::TWS_SKIP)
                & (state != tws_pkg::TWS_ADDR);
  wire in_frame  = (state == tws_pkg::TWS_TX) | (state == tws_pkg::TWS_ACK_IN)
                 | (state == tws_pkg::TWS_ACK_OUT);
  wire bus_err   = in_frame & (start_det | stop_det);

  // next state of the serial engine
  always_comb begin
    next_state = state;
    if (bus_err) begin
      next_state = tws_pkg::TWS_IDLE;
    end else if (start_det) begin
      next_state = tws_pkg::TWS_ADDR;
    end else if (stop_det) begin
      next_state = tws_pkg::TWS_IDLE;
    end else begin
      unique case (state)
        tws_pkg::TWS_IDLE: next_state = tws_pkg::TWS_IDLE;
        tws_pkg::TWS_SKIP: next_state = tws_pkg::TWS_SKIP;
        tws_pkg::TWS_ADDR: begin
          if (scl_fall && bit_cnt == 4'h8)
            next_state = rd_hit ? tws_pkg::TWS_ACK_OUT : tws_pkg::TWS_SKIP;
        end
        tws_pkg::TWS_ACK_OUT: begin
          if (scl_fall) next_state = tws_pkg::TWS_WAIT_SW;
        end
        tws_pkg::TWS_WAIT_SW: begin
          // after c0h/c8h the clear drops the role; later clocks read ones
          if (int_clear)
            next_state = leaving ? tws_pkg::TWS_SKIP
                                 : tws_pkg::TWS_TX;
        end
        tws_pkg::TWS_TX: begin
          if (scl_fall && bit_cnt == 4'h7) next_state = tws_pkg::TWS_ACK_IN;
        end
        tws_pkg::TWS_ACK_IN: begin
          if (scl_rise) next_state = tws_pkg::TWS_WAIT_SW;
        end
      endcase
    end
    if (recover) next_state = tws_pkg::TWS_IDLE;
  end

  // state, bit counter and shifter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state   <= tws_pkg::TWS_IDLE;
      bit_cnt <= 4'h0;
      shifter <= 8'h00;
    end else begin
      state <= next_state;
      if (start_det) begin
        bit_cnt <= 4'h0;
      end else if (state == tws_pkg::TWS_ADDR && scl_rise) begin
        shifter <= {shifter[6:0], sda_s};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (state == tws_pkg::TWS_WAIT_SW && int_clear) begin
        shifter <= shift_data_reg;
        bit_cnt <= 4'h0;
      end else if (state == tws_pkg::TWS_TX && scl_fall) begin
        shifter <= {shifter[6:0], 1'b1};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // bus free tracking for the deferred start request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) bus_busy <= 1'b0;
    else if (start_det) bus_busy <= 1'b1;
    else if (stop_det) bus_busy <= 1'b0;
  end

  // control, status and data registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_control_reg <= tws_pkg::CONTROL_RESET;
      status_code_reg    <= tws_pkg::ST_IDLE;
      shift_data_reg     <= tws_pkg::DATA_RESET;
      own_address_reg    <= tws_pkg::OWN_RESET;
      last_byte          <= 1'b0;
    end else begin
      if (own_wr) own_address_reg <= reg_wdata;
      if (data_wr) shift_data_reg <= reg_wdata;
      if (ctl_wr) serial_control_reg <= reg_wdata;
      if (int_clear) begin
        status_code_reg <= tws_pkg::ST_IDLE;
        // the same write that clears the flag chooses the last byte
        last_byte       <= ~reg_wdata[tws_pkg::BIT_ACK];
      end
      // recovery: stop flag self clears, other bits kept as written
      if (recover) begin
        serial_control_reg[tws_pkg::BIT_STOP] <= 1'b0;
      end
      // hardware events set the interrupt flag; set wins over a clear
      if (bus_err) begin
        serial_control_reg[tws_pkg::BIT_INT] <= 1'b1;
        status_code_reg <= tws_pkg::ST_BUS_ERROR;
      end else if (state == tws_pkg::TWS_ACK_OUT && scl_fall) begin
        serial_control_reg[tws_pkg::BIT_INT] <= 1'b1;
        serial_control_reg[tws_pkg::BIT_ARBL] <= 1'b0;
        status_code_reg <= arb_lost_flag ? tws_pkg::ST_ARB_READ
                                         : tws_pkg::ST_ADDR_READ;
      end else if (state == tws_pkg::TWS_ACK_IN && scl_rise) begin
        serial_control_reg[tws_pkg::BIT_INT] <= 1'b1;
        if (last_byte)
          status_code_reg <= sda_s ? tws_pkg::ST_DATA_NACK
                                   : tws_pkg::ST_LAST_ACK;
        else
          status_code_reg <= sda_s ? tws_pkg::ST_DATA_NACK
                                   : tws_pkg::ST_DATA_ACK;
      end
      // start request bit self clears once the bus is free and the interrupt flag is clear
      if (start_request_flag && !bus_busy && !int_flag &&
          state == tws_pkg::TWS_IDLE && !ctl_wr) begin
        serial_control_reg[tws_pkg::BIT_START] <= 1'b0;
      end
    end
  end

  // after c0h or c8h the next clear drops the addressed role
  wire leaving = (status_code_reg == tws_pkg::ST_DATA_NACK) |
                 (status_code_reg == tws_pkg::ST_LAST_ACK);
  wire unused_involved = involved;

  // line drive: ack on address, data bits, clock stretch while flagged except after c0h/c8h
  always_ff @(posedge clk or posedge reset) begin
    if (reset) drive_sda_low <= 1'b0;
    else if (recover || bus_err) drive_sda_low <= 1'b0;
    else if (state == tws_pkg::TWS_ACK_OUT) drive_sda_low <= 1'b1;
    else if (state == tws_pkg::TWS_TX && !leaving)
      drive_sda_low <= ~shifter[7];
    else drive_sda_low <= 1'b0;
  end
  wire hold_scl = (state == tws_pkg::TWS_WAIT_SW) & int_flag & ~leaving
                & ~scl_s;
  logic scl_low;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) scl_low <= 1'b0;
    else scl_low <= hold_scl;
  end
  assign scl_out       = 1'b0;
  assign sda_out       = 1'b0;
  assign scl_oe_n      = ~scl_low;
  assign sda_oe_n      = ~drive_sda_low;
  assign start_pending = start_request_flag & bus_busy;

  // read data the cycle after the strobe
  logic [7:0] next_rdata;
  always_comb begin
    unique case (reg_addr)
      tws_pkg::ADDR_CONTROL: next_rdata = serial_control_reg;
      tws_pkg::ADDR_STATUS:  next_rdata = status_code_reg;
      tws_pkg::ADDR_DATA:    next_rdata = shift_data_reg;
      tws_pkg::ADDR_OWN:     next_rdata = own_address_reg;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) reg_rdata <= 8'h00;
    else if (reg_read) reg_rdata <= next_rdata;
  end
endmodule : tws_slave_tx

// ===== sim/tws_slave_tx_monitor.sv
// port checker for the two-wire slave transmitter
`timescale 1ns/1ps
module tws_slave_tx_monitor (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_n,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       start_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // recovery write: stop request 1 with the interrupt flag cleared
  sequence s_recover;
    reg_write && reg_addr == tws_pkg::ADDR_CONTROL && reg_wdata[4] &&
      !reg_wdata[3];
  endsequence
  sequence s_own_wr_rd;
    reg_write && reg_addr == tws_pkg::ADDR_OWN ##2
      reg_read && reg_addr == tws_pkg::ADDR_OWN;
  endsequence
  status_low_a: assert property (reg_read && reg_addr == 2'h1 |=>
    reg_rdata[2:0] == 3'h0) else $error("status code low bits set");
  rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  own_readback_a: assert property (s_own_wr_rd |=>
    reg_rdata == $past(reg_wdata, 3)) else $error("own address lost");
  sda_drive_a: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("data line pulled while clock high");
  scl_stretch_a: assert property ($fell(scl_oe_n) |-> !scl_in)
    else $error("clock pulled low while high");
  // stretch only ends through a software write; allow two cycles of latency
  scl_hold_a: assert property (!scl_oe_n && !reg_write &&
    !$past(reg_write) && !$past(reg_write, 2) |=> !scl_oe_n)
    else $error("clock released without software");
  recover_rel_a: assert property (s_recover |-> ##[1:4]
    (scl_oe_n && sda_oe_n)) else $error("lines not released");
  recover_ctl_a: assert property (s_recover ##2 reg_read &&
    reg_addr == 2'h0 |=> (reg_rdata & 8'h14) == ($past(reg_wdata, 3) &
    8'h04)) else $error("control bits wrong after recovery");
endmodule : tws_slave_tx_monitor

bind tws_slave_tx tws_slave_tx_monitor mon_u (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .start_pending(start_pending));

// ===== sim/tws_mst_model.sv
// behavioural two-wire master receiver on the far side of the bus
`timescale 1ns/1ps
module tws_mst_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_drv,
  output logic      sda_drv,
  output logic      stuck
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    stuck   = 1'b0;
  end
  // one bit; waits out slave stretching but gives up after a bound
  task automatic clk_bit(input logic b, output logic r);
    int n;
    sda_drv = b;
    #20;
    scl_drv = 1'b1;
    for (n = 0; n < 4000 && !scl; n++) #5;
    if (!scl) stuck = 1'b1;
    #40;
    r = sda;
    scl_drv = 1'b0;
    #20;
  endtask : clk_bit
  task automatic start();
    sda_drv = 1'b1;
    #20;
    scl_drv = 1'b1;
    #40;
    sda_drv = 1'b0;
    #40;
    scl_drv = 1'b0;
    #20;
  endtask : start
  task automatic stop();
    sda_drv = 1'b0;
    #20;
    scl_drv = 1'b1;
    #40;
    sda_drv = 1'b1;
    #40;
  endtask : stop
  // byte msb first, then the acknowledge bit; bit 0 of w is direction
  task automatic xfer(input logic [7:0] w, input logic k,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) clk_bit(w[i], r[i]);
    clk_bit(k, a);
  endtask : xfer
endmodule : tws_mst_model

// ===== sim/tws_slave_tx_tb.sv
// self-checking bench for the two-wire slave transmitter
`timescale 1ns/1ps
module tws_slave_tx_tb;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic       scl_oe_n, sda_oe_n, m_scl, m_sda, start_pending, stuck;
  wire        scl = m_scl & scl_oe_n;
  wire        sda = m_sda & sda_oe_n;
  int         n_mismatch = 0;
  int         comparisons = 0;
  logic [7:0] r;
  logic       a;
  always #2.5 clk = ~clk;
  tws_slave_tx dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n),
    .start_pending(start_pending));
  tws_mst_model mst_u (.scl(scl), .sda(sda), .scl_drv(m_scl),
    .sda_drv(m_sda), .stuck(stuck));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] ad, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // poll the status code under a bound, then compare
  task automatic wait_st(input logic [7:0] e);
    logic [7:0] d;
    for (int i = 0; i < 100; i++) begin
      rd(2'h1, d);
      if (d === e) break;
    end
    chk(d, e);
  endtask : wait_st
  task automatic t_reset();
    wait_st(tws_pkg::ST_IDLE);
    rd(2'h0, r);
    chk(r, tws_pkg::CONTROL_RESET);
    rd(2'h2, r);
    chk(r, tws_pkg::DATA_RESET);
    chk({scl_oe_n, sda_oe_n}, 8'h03);
  endtask : t_reset
  task automatic t_slave_tx();
    wr(2'h3, 8'hb5);
    rd(2'h3, r);
    chk(r, 8'hb5);
    wr(2'h0, 8'h04);
    mst_u.start();
    mst_u.xfer(8'hb5, 1'b1, r, a);
    chk(a, 8'h00);
    wait_st(tws_pkg::ST_ADDR_READ);
    chk(scl_oe_n, 8'h00);
    wr(2'h2, 8'ha5);
    wr(2'h0, 8'h04);
    mst_u.xfer(8'hff, 1'b0, r, a);
    chk(r, 8'ha5);
    wait_st(tws_pkg::ST_DATA_ACK);
    wr(2'h2, 8'h3c);
    wr(2'h0, 8'h00);
    mst_u.xfer(8'hff, 1'b0, r, a);
    chk(r, 8'h3c);
    wait_st(tws_pkg::ST_LAST_ACK);
    wr(2'h0, 8'h04);
    mst_u.xfer(8'hff, 1'b1, r, a);
    chk(r, 8'hff);
    mst_u.stop();
    wait_st(tws_pkg::ST_IDLE);
  endtask : t_slave_tx
  task automatic t_write_dir();
    mst_u.start();
    mst_u.xfer(8'hb4, 1'b1, r, a);
    chk(a, 8'h01);
    mst_u.stop();
    wait_st(tws_pkg::ST_IDLE);
  endtask : t_write_dir
  task automatic t_arb_noack();
    wr(2'h0, 8'h44);
    mst_u.start();
    mst_u.xfer(8'hb5, 1'b1, r, a);
    wait_st(tws_pkg::ST_ARB_READ);
    wr(2'h2, 8'h0f);
    wr(2'h0, 8'h04);
    mst_u.xfer(8'hff, 1'b1, r, a);
    chk(r, 8'h0f);
    wait_st(tws_pkg::ST_DATA_NACK);
    wr(2'h0, 8'h20);
    @(posedge clk);
    chk(start_pending, 8'h01);
    mst_u.start();
    mst_u.xfer(8'hb5, 1'b1, r, a);
    chk(a, 8'h01);
    mst_u.stop();
    for (int i = 0; i < 200 && start_pending; i++) @(posedge clk);
    chk(start_pending, 8'h00);
    wr(2'h0, 8'h04);
    mst_u.start();
    mst_u.xfer(8'hb5, 1'b1, r, a);
    chk(a, 8'h00);
  endtask : t_arb_noack
  // illegal start in mid-byte while addressed, then software recovery
  task automatic t_bus_err();
    wait_st(tws_pkg::ST_ADDR_READ);
    wr(2'h2, 8'hff);
    wr(2'h0, 8'h04);
    repeat (3) mst_u.clk_bit(1'b1, a);
    mst_u.start();
    wait_st(tws_pkg::ST_BUS_ERROR);
    rd(2'h0, r);
    chk(r & 8'h08, 8'h08);
    wr(2'h0, 8'h14);
    rd(2'h0, r);
    chk(r, 8'h04);
    wait_st(tws_pkg::ST_IDLE);
    chk({scl_oe_n, sda_oe_n}, 8'h03);
    mst_u.stop();
  endtask : t_bus_err
  task automatic final_report();
    $display("n_mismatch=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_slave_tx();
    t_write_dir();
    t_arb_noack();
    t_bus_err();
    chk(stuck, 8'h00);
    final_report();
  end
  // a hang anywhere ends the run as a failure
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule : tws_slave_tx_tb
